/* hdl/tafq_conv_timer.sv */
// Conversion pacing timer: one pulse per conversion period
`timescale 1ns/1ps
`default_nettype none
module tafq_conv_timer #(
	parameter int unsigned PERIOD = 32'd5320000
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Control
	input wire logic hold_i,
	// Tick
	output logic tick_o
);
	logic [31:0] count;
	wire last = (count == PERIOD - 32'd1);
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i || hold_i)
		begin
			count <= 32'h0;
			tick_o <= 1'b0;
		end
		else
		begin
			count <= last ? 32'h0 : count + 32'h1;
			tick_o <= last;
		end
	end
endmodule
`default_nettype wire

/* hdl/tafq_core.sv */
// Alarm decision logic: result register, fault queue and alarm output
// Operation
// - Result register holds 8000 after reset until a conversion lands.
// - Results are two's-complement, left-justified in sixteen bits.
// - 12-bit variant keeps three extra fraction bits; 9-bit variant truncates.
// - Results change the alarm only when consecutive fault count reaches queue depth.
// - Out of limit means above upper trip or below lower release.
// - Queue depth defaults to one; selectable one, two, four or six.
// - In-limit result with alarm idle clears the partial fault count.
// - Queue clears at reset, during shutdown, and on limit or config writes.
// - Every queue clear deasserts the alarm in both modes.
// - Comparator mode asserts after depth consecutive results above upper limit.
// - Comparator mode deasserts after depth consecutive results below lower limit.
// - Interrupt mode seeks an upper-limit fault first after any clear.
// - Interrupt mode alternates upper and lower fault searches, depth-qualified.
// - Interrupt alarm latches until any register read, then seeks opposite.
// - Any queue clear in interrupt mode returns search to upper fault.
// - Shutdown stops conversions and forces the result to 8000.
// - After shutdown, result reads 8000 until the first new conversion.
// - Config bit 0 selects shutdown when set.
// - Config bit 1 selects interrupt mode when set.
// - Config bit 2 makes the alarm active high when set.
// - Conversions run every 133 ms; each result feeds the queue except while the interrupt alarm is latched or a queue clear falls in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "tafq_regs.svh"
module tafq_core #(
	parameter int unsigned CONV_CYCLES = `TAFQ_CONV_CYCLES,
	parameter bit RES12 = 1'b0
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Converter sample input, taken on each conversion tick
	input wire logic [15:0] adc_code_i,
	// Register writes and reads from the bus front end
	input wire logic cfg_wr_i,
	input wire tafq_pkg::tafq_cfg_type cfg_wdata_i,
	input wire logic high_wr_i,
	input wire logic low_wr_i,
	input wire logic [15:0] limit_wdata_i,
	input wire logic reg_rd_i,
	// Register contents
	output logic [15:0] temp_result_o,
	output tafq_pkg::tafq_cfg_type cfg_o,
	output logic [15:0] upper_trip_limit_o,
	output logic [15:0] lower_release_limit_o,
	// Status
	output logic conv_done_o,
	output logic alarm_active_o,
	output logic [2:0] fault_count_o,
	output logic seek_low_o,
	// Pin
	output logic alarm_out_o
);
	import tafq_pkg::*;

	function automatic logic [2:0] depth_of(input logic [1:0] sel);
		case (sel)
			2'd0: depth_of = 3'd1;
			2'd1: depth_of = 3'd2;
			2'd2: depth_of = 3'd4;
			default: depth_of = 3'd6;
		endcase
	endfunction

	logic tick;
	tafq_seek_type seek;
	tafq_seek_type next_seek;
	logic alarm;
	logic next_alarm;
	logic [2:0] count;
	logic [2:0] next_count;

	tafq_conv_timer #(
		.PERIOD(CONV_CYCLES)
	) u_timer (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.hold_i(cfg_o.shutdown),
		.tick_o(tick)
	);

	wire [15:0] res_mask = RES12 ? `TAFQ_RES12_MASK : `TAFQ_RES9_MASK;
	wire [15:0] sample = adc_code_i & res_mask;
	wire conv = tick && !cfg_o.shutdown;
	wire above = $signed(sample) > $signed(upper_trip_limit_o);
	wire below = $signed(sample) < $signed(lower_release_limit_o);
	wire [2:0] depth = depth_of(cfg_o.depth);
	wire q_clear = cfg_o.shutdown || cfg_wr_i || high_wr_i || low_wr_i;
	// Comparator mode looks for the fault that would flip the alarm
	wire cmp_fault = alarm ? below : above;
	wire int_fault = (seek == TAFQ_SEEK_HIGH) ? above : below;
	wire fault = cfg_o.int_mode ? int_fault : cmp_fault;
	wire [2:0] count_inc = count + 3'd1;
	wire hit = (count_inc >= depth);

	always_comb
	begin
		next_count = count;
		next_alarm = alarm;
		next_seek = seek;
		if (q_clear)
		begin
			next_count = 3'd0;
			next_alarm = 1'b0;
			next_seek = TAFQ_SEEK_HIGH;
		end
		else
		begin
			// A read releases a latched interrupt; the search turns round
			if (cfg_o.int_mode && alarm && reg_rd_i)
			begin
				next_alarm = 1'b0;
				next_count = 3'd0;
				next_seek = (seek == TAFQ_SEEK_HIGH) ? TAFQ_SEEK_LOW : TAFQ_SEEK_HIGH;
			end
			else if (conv)
			begin
				if (cfg_o.int_mode && alarm)
					next_count = 3'd0;
				else if (fault && hit)
				begin
					next_count = 3'd0;
					// Comparator toggles; interrupt latches high
					next_alarm = cfg_o.int_mode ? 1'b1 : !alarm;
				end
				else if (fault)
					next_count = count_inc;
				else
					next_count = 3'd0;
			end
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			count <= 3'd0;
			alarm <= 1'b0;
			seek <= TAFQ_SEEK_HIGH;
		end
		else
		begin
			count <= next_count;
			alarm <= next_alarm;
			seek <= next_seek;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			cfg_o <= `TAFQ_CFG_RESET;
			upper_trip_limit_o <= `TAFQ_HIGH_RESET;
			lower_release_limit_o <= `TAFQ_LOW_RESET;
		end
		else
		begin
			// Reserved config bits stay zero whatever is written
			if (cfg_wr_i)
				cfg_o <= cfg_wdata_i & `TAFQ_CFG_MASK;
			if (high_wr_i)
				upper_trip_limit_o <= limit_wdata_i & `TAFQ_LIM_MASK;
			if (low_wr_i)
				lower_release_limit_o <= limit_wdata_i & `TAFQ_LIM_MASK;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			temp_result_o <= `TAFQ_TEMP_RESET;
		else if (cfg_o.shutdown)
			temp_result_o <= `TAFQ_TEMP_RESET;
		else if (conv)
			temp_result_o <= sample;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			conv_done_o <= 1'b0;
			alarm_active_o <= 1'b0;
			fault_count_o <= 3'd0;
			seek_low_o <= 1'b0;
			alarm_out_o <= 1'b1;
		end
		else
		begin
			conv_done_o <= conv;
			alarm_active_o <= next_alarm;
			fault_count_o <= next_count;
			seek_low_o <= (next_seek == TAFQ_SEEK_LOW);
			// Pin polarity follows the config written in this same cycle
			alarm_out_o <= next_alarm ~^ (cfg_wr_i ? cfg_wdata_i.polarity : cfg_o.polarity);
		end
	end

	property p_reset_code;
		@(posedge sys_clk_i) $fell(reset_i) |-> temp_result_o == 16'h8000;
	endproperty
	a_reset_code: assert property (p_reset_code) else $error("result not 8000 after reset");

	// A register missed by the reset branch shows up on the first edge after release
	property p_reset_idle;
		@(posedge sys_clk_i) disable iff (reset_i)
			$past(reset_i) |-> temp_result_o == 16'h8000 && !alarm_active_o && fault_count_o == 3'd0
				&& !seek_low_o && cfg_o == `TAFQ_CFG_RESET && upper_trip_limit_o == `TAFQ_HIGH_RESET;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");

	property p_shdn_code;
		@(posedge sys_clk_i) disable iff (reset_i) cfg_o.shutdown |=> temp_result_o == 16'h8000;
	endproperty
	a_shdn_code: assert property (p_shdn_code) else $error("result not forced in shutdown");
	property p_res_mask;
		@(posedge sys_clk_i) disable iff (reset_i) (temp_result_o & ~res_mask) == 16'h0;
	endproperty
	a_res_mask: assert property (p_res_mask) else $error("low result bits not zero");
	property p_clear_drops;
		@(posedge sys_clk_i) disable iff (reset_i) q_clear |=> !alarm_active_o && fault_count_o == 3'd0;
	endproperty
	a_clear_drops: assert property (p_clear_drops) else $error("clear did not drop alarm");
	property p_clear_seek;
		@(posedge sys_clk_i) disable iff (reset_i) q_clear |=> !seek_low_o;
	endproperty
	a_clear_seek: assert property (p_clear_seek) else $error("clear did not seek upper");
	property p_read_release;
		@(posedge sys_clk_i) disable iff (reset_i)
			(cfg_o.int_mode && alarm && reg_rd_i && !q_clear) |=> !alarm_active_o && (seek_low_o != $past(seek_low_o));
	endproperty
	a_read_release: assert property (p_read_release) else $error("read did not release alarm");
	property p_count_bound;
		@(posedge sys_clk_i) disable iff (reset_i) fault_count_o < depth_of(cfg_o.depth);
	endproperty
	a_count_bound: assert property (p_count_bound) else $error("fault count reached depth");
	property p_no_conv_shdn;
		@(posedge sys_clk_i) disable iff (reset_i) cfg_o.shutdown |-> !conv_done_o || $past(!cfg_o.shutdown);
	endproperty
	a_no_conv_shdn: assert property (p_no_conv_shdn) else $error("conversion during shutdown");
	property p_pin_pol;
		@(posedge sys_clk_i) disable iff (reset_i) alarm_out_o == (alarm_active_o ~^ cfg_o.polarity);
	endproperty
	a_pin_pol: assert property (p_pin_pol) else $error("alarm pin polarity wrong");

	property p_conv_result;
		@(posedge sys_clk_i) disable iff (reset_i)
			conv |=> conv_done_o && temp_result_o == ($past(adc_code_i) & res_mask);
	endproperty
	a_conv_result: assert property (p_conv_result) else $error("conversion not taken into result");

	property p_cmp_rise;
		@(posedge sys_clk_i) disable iff (reset_i)
			!q_clear && !cfg_o.int_mode && !alarm_active_o && conv && above
				&& fault_count_o + 3'd1 == depth |=> alarm_active_o;
	endproperty
	a_cmp_rise: assert property (p_cmp_rise) else $error("comparator alarm did not assert");

	property p_cmp_fall;
		@(posedge sys_clk_i) disable iff (reset_i)
			!q_clear && !cfg_o.int_mode && alarm_active_o && conv && below
				&& fault_count_o + 3'd1 == depth |=> !alarm_active_o;
	endproperty
	a_cmp_fall: assert property (p_cmp_fall) else $error("comparator alarm did not release");

	property p_in_limit;
		@(posedge sys_clk_i) disable iff (reset_i)
			!q_clear && conv && !above && !below && !alarm_active_o |=> fault_count_o == 3'd0;
	endproperty
	a_in_limit: assert property (p_in_limit) else $error("in-limit result kept fault count");

	property p_int_rise;
		@(posedge sys_clk_i) disable iff (reset_i)
			cfg_o.int_mode && $rose(alarm_active_o) |-> $past(conv) && seek_low_o == $past(seek_low_o);
	endproperty
	a_int_rise: assert property (p_int_rise) else $error("interrupt alarm rose without conversion");

	property p_int_latch;
		@(posedge sys_clk_i) disable iff (reset_i)
			cfg_o.int_mode && alarm_active_o && !reg_rd_i && !q_clear |=> alarm_active_o;
	endproperty
	a_int_latch: assert property (p_int_latch) else $error("interrupt alarm not latched");

	// Only a conversion, a clear or a read may move the alarm
	property p_alarm_steady;
		@(posedge sys_clk_i) disable iff (reset_i)
			!$past(reset_i) && $changed(alarm_active_o) |-> $past(conv || q_clear || reg_rd_i);
	endproperty
	a_alarm_steady: assert property (p_alarm_steady) else $error("alarm moved without cause");

	property p_seek_hold;
		@(posedge sys_clk_i) disable iff (reset_i)
			!$past(reset_i) && $changed(seek_low_o) |-> $past(q_clear || reg_rd_i);
	endproperty
	a_seek_hold: assert property (p_seek_hold) else $error("search turned without read or clear");

	property p_restart_code;
		@(posedge sys_clk_i) disable iff (reset_i)
			$fell(cfg_o.shutdown) |-> temp_result_o == 16'h8000;
	endproperty
	a_restart_code: assert property (p_restart_code) else $error("result not 8000 after shutdown");

	property p_limit_fmt;
		@(posedge sys_clk_i) disable iff (reset_i)
			upper_trip_limit_o[6:0] == 7'h00 && lower_release_limit_o[6:0] == 7'h00 && cfg_o.rsvd == 3'h0;
	endproperty
	a_limit_fmt: assert property (p_limit_fmt) else $error("limit or config reserved bits set");

	c_cmp_assert: cover property (@(posedge sys_clk_i) !cfg_o.int_mode && $rose(alarm_active_o));
	c_cmp_release: cover property (@(posedge sys_clk_i) !cfg_o.int_mode && $fell(alarm_active_o) && conv_done_o);
	c_int_low: cover property (@(posedge sys_clk_i) cfg_o.int_mode && seek_low_o && $rose(alarm_active_o));
	c_deep_queue: cover property (@(posedge sys_clk_i) fault_count_o == 3'd5);
endmodule
`default_nettype wire

/* hdl/tafq_pkg.sv */
// Types for the temperature alarm fault queue block
package tafq_pkg;
	typedef enum logic [1:0] {TAFQ_SEEK_HIGH, TAFQ_SEEK_LOW} tafq_seek_type;
	typedef struct packed {
		logic [2:0] rsvd;
		logic [1:0] depth;
		logic polarity;
		logic int_mode;
		logic shutdown;
	} tafq_cfg_type;
	typedef struct packed {
		logic valid;
		logic [15:0] code;
	} tafq_sample_type;
endpackage

/* hdl/tafq_regs.svh */
// Constants for the temperature alarm fault queue block
`ifndef TAFQ_REGS_SVH
`define TAFQ_REGS_SVH
`define TAFQ_TEMP_RESET 16'h8000
`define TAFQ_HIGH_RESET 16'h5000
`define TAFQ_LOW_RESET 16'h4b00
`define TAFQ_CFG_RESET 8'h00
`define TAFQ_CFG_SHDN 0
`define TAFQ_CFG_MODE 1
`define TAFQ_CFG_POL 2
`define TAFQ_CFG_QLO 3
`define TAFQ_CFG_QHI 4
`define TAFQ_CFG_MASK 8'h1f
`define TAFQ_LIM_MASK 16'hff80
`define TAFQ_RES9_MASK 16'hff80
`define TAFQ_RES12_MASK 16'hfff0
`define TAFQ_CONV_PERIOD_MS 133
`define TAFQ_CLK_HZ 40000000
// Divide first: the full product of period and clock overflows 32-bit arithmetic
`define TAFQ_CONV_CYCLES (`TAFQ_CONV_PERIOD_MS * (`TAFQ_CLK_HZ / 1000))
`endif

/* verification/tafq_core_tb.sv */
// Self-checking testbench for the alarm decision core
`timescale 1ns/1ps
`default_nettype none
module tafq_core_tb;
	import tafq_pkg::*;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic cw, hw, lw, rd, done, act, seek, pin;
	tafq_cfg_type cd, cq;
	logic [15:0] lim, adc, temp, up, low;
	logic [2:0] cnt;
	int err_count = 0;
	int cmp_count = 0;
	int n;
	always #12.5 sys_clk_i = ~sys_clk_i;
	tafq_master_model m (.sys_clk_i(sys_clk_i), .cfg_wr_o(cw), .cfg_wdata_o(cd), .high_wr_o(hw),
		.low_wr_o(lw), .limit_wdata_o(lim), .reg_rd_o(rd), .adc_code_o(adc));
	tafq_core #(.CONV_CYCLES(8), .RES12(1'b1)) uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.adc_code_i(adc), .cfg_wr_i(cw), .cfg_wdata_i(cd), .high_wr_i(hw), .low_wr_i(lw),
		.limit_wdata_i(lim), .reg_rd_i(rd), .temp_result_o(temp), .cfg_o(cq),
		.upper_trip_limit_o(up), .lower_release_limit_o(low), .conv_done_o(done),
		.alarm_active_o(act), .fault_count_o(cnt), .seek_low_o(seek), .alarm_out_o(pin));
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		cmp_count++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask
	// Waits for the result of the next conversion tick
	task automatic conv(input logic [15:0] c);
		int i;
		m.set_adc(c);
		#1;
		for (i = 0; i < 40 && done !== 1'b1; i++)
		begin
			@(posedge sys_clk_i);
			#1;
		end
		chk("conv", 16'(i == 40), 16'h0000);
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		#100us;
		err_count++;
		print_verdict();
	end
	initial
	begin
		repeat (3) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		#1;
		chk("temp", temp, 16'h8000);
		chk("pin", 16'(pin), 16'h0001);
		conv(16'h7cf4);
		chk("temp", temp, 16'h7cf0);
		conv(16'hff80);
		chk("temp", temp, 16'hff80);
		$display("format test done");
		for (int d = 0; d < 4; d++)
		begin
			n = (d == 0) ? 1 : d * 2;
			m.acc(4'h1, 16'(d * 8 + 4));
			conv(16'h5000);
			chk("count", 16'(cnt), 16'h0000);
			repeat (n - 1) conv(16'h5080);
			conv(16'h4c00);
			chk("count", 16'(cnt), 16'h0000);
			repeat (n - 1) conv(16'h5080);
			chk("alarm", 16'(act), 16'h0000);
			conv(16'h5080);
			chk("pin", 16'(pin), 16'h0001);
			repeat (n - 1) conv(16'h4a00);
			chk("alarm", 16'(act), 16'h0001);
			conv(16'h4a00);
			chk("alarm", 16'(act), 16'h0000);
		end
		m.acc(4'h1, 16'h0000);
		conv(16'h5080);
		chk("pin", 16'(pin), 16'h0000);
		m.acc(4'h2, 16'h50ff);
		chk("upper", up, 16'h5080);
		chk("alarm", 16'({act, cnt}), 16'h0000);
		$display("comparator test done");
		m.acc(4'h1, 16'h00e2);
		chk("cfg", 16'(cq), 16'h0002);
		conv(16'h4a00);
		chk("alarm", 16'(act), 16'h0000);
		conv(16'h5100);
		chk("pin", 16'(pin), 16'h0000);
		conv(16'h4a00);
		chk("alarm", 16'(act), 16'h0001);
		m.acc(4'h8, 16'h0000);
		chk("seek", 16'({act, seek}), 16'h0001);
		conv(16'h5100);
		chk("alarm", 16'(act), 16'h0000);
		conv(16'h4a00);
		chk("alarm", 16'(act), 16'h0001);
		m.acc(4'h8, 16'h0000);
		conv(16'h5100);
		chk("alarm", 16'(act), 16'h0001);
		m.acc(4'h4, 16'h4b7f);
		chk("seek", 16'({act, seek}), 16'h0000);
		chk("lower", low, 16'h4b00);
		$display("interrupt test done");
		m.acc(4'h1, 16'h0001);
		repeat (20)
		begin
			@(posedge sys_clk_i);
			#1;
			chk("done", 16'(done), 16'h0000);
		end
		chk("temp", temp, 16'h8000);
		chk("count", 16'(cnt), 16'h0000);
		m.acc(4'h1, 16'h0000);
		chk("temp", temp, 16'h8000);
		conv(16'h1900);
		chk("temp", temp, 16'h1900);
		$display("shutdown test done");
		m.acc(4'h1, 16'h0004);
		chk("pin", 16'(pin), 16'h0000);
		@(posedge sys_clk_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		#1;
		chk("temp", temp, 16'h8000);
		chk("pin", 16'(pin), 16'h0001);
		chk("cfg", 16'(cq), 16'h0000);
		chk("upper", up, 16'h5000);
		$display("reset test done");
		print_verdict();
	end
endmodule
`default_nettype wire

/* verification/tafq_master_model.sv */
// Bus master model: register strobes and converter samples
`timescale 1ns/1ps
`default_nettype none
module tafq_master_model (
	// Clock
	input wire logic sys_clk_i,
	// Register access
	output logic cfg_wr_o,
	output tafq_pkg::tafq_cfg_type cfg_wdata_o,
	output logic high_wr_o,
	output logic low_wr_o,
	output logic [15:0] limit_wdata_o,
	output logic reg_rd_o,
	// Converter
	output logic [15:0] adc_code_o
);
	import tafq_pkg::*;
	initial
	begin
		{cfg_wr_o, high_wr_o, low_wr_o, reg_rd_o} = 4'h0;
		cfg_wdata_o = 8'h00;
		limit_wdata_o = 16'h0000;
		adc_code_o = 16'h0000;
	end
	// One-cycle access; sel is {read, low, high, config}
	task automatic acc(input logic [3:0] sel, input logic [15:0] d);
		@(posedge sys_clk_i);
		{reg_rd_o, low_wr_o, high_wr_o, cfg_wr_o} <= sel;
		cfg_wdata_o <= d[7:0];
		limit_wdata_o <= d;
		@(posedge sys_clk_i);
		{reg_rd_o, low_wr_o, high_wr_o, cfg_wr_o} <= 4'h0;
		// Released data flips so stale values cannot match by luck
		cfg_wdata_o <= ~d[7:0];
		limit_wdata_o <= ~d;
		#1;
	endtask
	task automatic set_adc(input logic [15:0] c);
		@(posedge sys_clk_i);
		adc_code_o <= c;
	endtask
endmodule
`default_nettype wire
